// ---- core/rlx_pkg.sv ----
package rlx_pkg;
	// clock and time base
	localparam int CLK_HZ = 50000000;
	localparam int TICK_S = 1;
	localparam int TICK_CYCLES = CLK_HZ * TICK_S;
	localparam int OCV_WAIT_MIN = 30;
	localparam logic [15:0] OCV_WAIT_S = 16'(OCV_WAIT_MIN * 60);
	localparam logic signed [15:0] DVDT_MAX_UV = 16'sh0004;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PROF = 8'h04;
	localparam logic [7:0] OFF_DSG_THR = 8'h08;
	localparam logic [7:0] OFF_CHG_THR = 8'h0C;
	localparam logic [7:0] OFF_QUIT = 8'h10;
	localparam logic [7:0] OFF_DSG_RELAX = 8'h14;
	localparam logic [7:0] OFF_CHG_RELAX = 8'h18;
	localparam logic [7:0] OFF_QUIT_RELAX = 8'h1C;
	localparam logic [7:0] OFF_STEP = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	localparam logic [7:0] OFF_QMAX = 8'h28;
	localparam logic [7:0] OFF_CYCLE = 8'h2C;
	localparam logic [7:0] OFF_DOD = 8'h30;
	localparam logic [7:0] OFF_AVG_I = 8'h34;
	localparam logic [7:0] OFF_AVG_P = 8'h38;
	localparam logic [7:0] OFF_PULSE = 8'h3C;
	localparam logic [7:0] OFF_OCV = 8'h40;
	// reset values
	localparam logic [15:0] DSG_THR_RST = 16'h003C;
	localparam logic [15:0] CHG_THR_RST = 16'h004B;
	localparam logic [15:0] QUIT_RST = 16'h0028;
	localparam logic [15:0] DSG_RELAX_RST = 16'h0708;
	localparam logic [15:0] CHG_RELAX_RST = 16'h003C;
	localparam logic [15:0] QUIT_RELAX_RST = 16'h0001;
	localparam logic [15:0] STEP_RST = 16'h000A;
	localparam logic [15:0] PULSE_RST = 16'h0002;
	localparam logic [15:0] QMAX_RST = 16'h03E8;
	localparam logic [1:0] PROF_RST = 2'h0;
	// field positions and learning codes
	localparam int PROF_UNSUP_BIT = 1;
	localparam int PROF_LAST_BIT = 0;
	localparam int CTRL_GAUGE_BIT = 0;
	localparam logic [7:0] LEARN_QMAX = 8'h01;
	localparam logic [7:0] LEARN_BOTH = 8'h02;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// current-flow tracking states, gray along flow->discharge wait->relax->exit
	typedef enum logic [2:0] {
		ST_FLOW = 3'h0,
		ST_DSG_WAIT = 3'h1,
		ST_RELAX = 3'h3,
		ST_EXIT = 3'h2,
		ST_CHG_WAIT = 3'h7
	} rlx_state_t;
endpackage

// ---- core/rlx_timer_if.sv ----
`timescale 1ns/1ps
interface rlx_timer_if;
	logic tick; // one-second pulse
	logic run; // count while high, clear while low
	logic [15:0] limit; // expiry in seconds
	logic expired; // level, run held and limit reached
	modport ctl (output tick, output run, output limit, input expired);
	modport tmr (input tick, input run, input limit, output expired);
endinterface

// ---- core/rlx_timer.sv ----
`timescale 1ns/1ps
module rlx_timer import rlx_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control
	rlx_timer_if.tmr tif
);
	logic [15:0] cnt_reg; // elapsed seconds
	logic exp_reg; // expiry flag
	assign tif.expired = exp_reg;
	// dropping run clears the count, so a restart always begins at zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 16'h0000;
			exp_reg <= 1'b0;
		end else if (!tif.run) begin
			cnt_reg <= 16'h0000;
			exp_reg <= 1'b0;
		end else begin
			if (tif.tick && cnt_reg < tif.limit) begin
				cnt_reg <= cnt_reg + 16'h0001;
			end
			exp_reg <= (cnt_reg >= tif.limit);
		end
	end
endmodule

// ---- core/rlx_tracker.sv ----
`timescale 1ns/1ps
// Summary of operation
// - discharge-mode flag clear only while average current positive
// - discharge flowing only beyond discharge-detect threshold
// - charge flowing only above charge-detect threshold
// - rise into quit band starts discharge relax timer
// - fall into quit band starts charge relax timer
// - after 30 min relaxed, take OCV when slope small
// - quit level defaults 40 mA, below detect thresholds
// - leave relaxation after flow held quit-relax delay
// - enabling gauging sets learning 0x01 and enabled flag
// - profile byte: reserved high, unsupported, last profile
// - per-cell max capacity, default 1000, kept updated
// - per-cell cycle count counts capacity updates
// - learning bits 0x01 capacity, 0x02 both
// - last-run average discharge current recorded
// - last-run average discharge power recorded
// - pulse voltage difference defaults to 2 mV
// - pulse difference change per grid update limited
// - per-cell end-of-charge depth, default 0
module rlx_tracker import rlx_pkg::*; #(
	parameter int TICKS = TICK_CYCLES
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// measurements, same clock
	input wire logic meas_valid,
	input wire logic signed [15:0] meas_cur,
	input wire logic signed [15:0] meas_avg,
	input wire logic [15:0] meas_volt,
	input wire logic signed [15:0] meas_dvdt,
	// learning events
	input wire logic grid_upd,
	input wire logic [15:0] grid_delta,
	input wire logic qmax_upd,
	input wire logic [15:0] qmax_value,
	input wire logic learn_qmax,
	input wire logic learn_imp,
	input wire logic dod_upd,
	input wire logic [15:0] dod_value,
	// state outputs
	output logic dsg_mode,
	output logic dsg_flow,
	output logic chg_flow,
	output logic relax_active,
	output logic ocv_take,
	output logic [15:0] ocv_voltage,
	output logic gauging_enabled_flag
);
	// reset release chain
	logic rst_s1_reg, rst_n;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
		end
	end

	// bus state
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic aw_hold_reg, w_hold_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] wr_data_reg, rdata_reg, rd_word;
	logic [3:0] wr_strb_reg;
	logic rd_ok, wr_ok;
	// configuration and status
	logic gauge_en_reg;
	logic [1:0] prof_reg;
	logic [15:0] dsg_thr_reg, chg_thr_reg, quit_reg, dsg_relax_reg, chg_relax_reg;
	logic [15:0] quit_relax_reg, step_reg, pulse_reg;
	logic [15:0] qmax_reg [2];
	logic [15:0] cyc_reg [2];
	logic [15:0] dod_reg [2];
	logic [7:0] upd_reg [2];
	// tracker state
	rlx_state_t state_reg, state_next;
	logic prev_below_reg, prev_above_reg, ocv_done_reg;
	logic dsg_mode_reg, dsg_flow_reg, chg_flow_reg, relax_reg, ocv_take_reg;
	logic [15:0] ocv_volt_reg;
	logic [31:0] tick_cnt_reg;
	logic tick_reg;
	// last-run averaging
	logic signed [39:0] isum_reg;
	logic signed [55:0] psum_reg;
	logic [23:0] n_reg;
	logic signed [15:0] avg_i_reg;
	logic signed [31:0] avg_p_reg;

	rlx_timer_if ph_if ();
	rlx_timer_if rx_if ();

	// output wiring, all from flops
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign dsg_mode = dsg_mode_reg;
	assign dsg_flow = dsg_flow_reg;
	assign chg_flow = chg_flow_reg;
	assign relax_active = relax_reg;
	assign ocv_take = ocv_take_reg;
	assign ocv_voltage = ocv_volt_reg;
	assign gauging_enabled_flag = gauge_en_reg;

	// handshake decode
	wire aw_fire = s_axi_awvalid && awready_reg;
	wire w_fire = s_axi_wvalid && wready_reg;
	wire ar_fire = s_axi_arvalid && arready_reg;
	wire wr_en = aw_hold_reg && w_hold_reg && !bvalid_reg;
	wire aw_hold_next = (aw_hold_reg || aw_fire) && !wr_en;
	wire w_hold_next = (w_hold_reg || w_fire) && !wr_en;
	// register write strobes
	wire wr_ctrl = wr_en && wr_addr_reg == OFF_CTRL;
	wire wr_prof = wr_en && wr_addr_reg == OFF_PROF;
	wire wr_qmax = wr_en && wr_addr_reg == OFF_QMAX;
	wire wr_pulse = wr_en && wr_addr_reg == OFF_PULSE;
	wire cell_sel = prof_reg[PROF_LAST_BIT];
	wire gauge_rise = wr_ctrl && wr_strb_reg[0] && wr_data_reg[CTRL_GAUGE_BIT] && !gauge_en_reg;

	// byte-lane merge for the 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old);
		merge16 = old;
		if (wr_strb_reg[0]) merge16[7:0] = wr_data_reg[7:0];
		if (wr_strb_reg[1]) merge16[15:8] = wr_data_reg[15:8];
	endfunction

	// write channel: address and data taken in either order
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 32'h00000000;
			wr_strb_reg <= 4'h0;
		end else begin
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			awready_reg <= !aw_hold_next;
			wready_reg <= !w_hold_next;
			if (aw_fire) wr_addr_reg <= s_axi_awaddr;
			if (w_fire) begin
				wr_data_reg <= s_axi_wdata;
				wr_strb_reg <= s_axi_wstrb;
			end
			if (wr_en) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// writable offsets; read-only ones answer okay and are ignored
	assign wr_ok = (wr_addr_reg <= OFF_OCV) && (wr_addr_reg[1:0] == 2'h0);

	// read data selection, reserved bits read zero
	always_comb begin
		rd_ok = 1'b1;
		rd_word = 32'h00000000;
		case (s_axi_araddr)
			OFF_CTRL: rd_word = {31'h0, gauge_en_reg};
			OFF_PROF: rd_word = {30'h0, prof_reg};
			OFF_DSG_THR: rd_word = {16'h0, dsg_thr_reg};
			OFF_CHG_THR: rd_word = {16'h0, chg_thr_reg};
			OFF_QUIT: rd_word = {16'h0, quit_reg};
			OFF_DSG_RELAX: rd_word = {16'h0, dsg_relax_reg};
			OFF_CHG_RELAX: rd_word = {16'h0, chg_relax_reg};
			OFF_QUIT_RELAX: rd_word = {16'h0, quit_relax_reg};
			OFF_STEP: rd_word = {16'h0, step_reg};
			OFF_STATUS: rd_word = {16'h0, upd_reg[cell_sel], 1'b0, state_reg, relax_reg,
				chg_flow_reg, dsg_flow_reg, dsg_mode_reg};
			OFF_QMAX: rd_word = {16'h0, qmax_reg[cell_sel]};
			OFF_CYCLE: rd_word = {16'h0, cyc_reg[cell_sel]};
			OFF_DOD: rd_word = {16'h0, dod_reg[cell_sel]};
			OFF_AVG_I: rd_word = {{16{avg_i_reg[15]}}, avg_i_reg};
			OFF_AVG_P: rd_word = avg_p_reg;
			OFF_PULSE: rd_word = {16'h0, pulse_reg};
			OFF_OCV: rd_word = {16'h0, ocv_volt_reg};
			default: rd_ok = 1'b0; // unmapped, slave error
		endcase
	end

	// read channel, answer one cycle after the address is taken
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end else if (ar_fire) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (!rvalid_reg || s_axi_rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// configuration registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gauge_en_reg <= 1'b0;
			prof_reg <= PROF_RST;
			dsg_thr_reg <= DSG_THR_RST;
			chg_thr_reg <= CHG_THR_RST;
			quit_reg <= QUIT_RST;
			dsg_relax_reg <= DSG_RELAX_RST;
			chg_relax_reg <= CHG_RELAX_RST;
			quit_relax_reg <= QUIT_RELAX_RST;
			step_reg <= STEP_RST;
		end else if (wr_en) begin
			if (wr_ctrl && wr_strb_reg[0]) gauge_en_reg <= wr_data_reg[CTRL_GAUGE_BIT];
			if (wr_prof && wr_strb_reg[0]) prof_reg <= wr_data_reg[1:0];
			if (wr_addr_reg == OFF_DSG_THR) dsg_thr_reg <= merge16(dsg_thr_reg);
			if (wr_addr_reg == OFF_CHG_THR) chg_thr_reg <= merge16(chg_thr_reg);
			if (wr_addr_reg == OFF_QUIT) quit_reg <= merge16(quit_reg);
			if (wr_addr_reg == OFF_DSG_RELAX) dsg_relax_reg <= merge16(dsg_relax_reg);
			if (wr_addr_reg == OFF_CHG_RELAX) chg_relax_reg <= merge16(chg_relax_reg);
			if (wr_addr_reg == OFF_QUIT_RELAX) quit_relax_reg <= merge16(quit_relax_reg);
			if (wr_addr_reg == OFF_STEP) step_reg <= merge16(step_reg);
		end
	end

	// per-cell learned records, only the last-used cell moves
	for (genvar c = 0; c < 2; c++) begin : g_cell
		wire sel = (cell_sel == 1'(c));
		wire [7:0] learn_bits = (learn_qmax ? LEARN_QMAX : 8'h00) | (learn_imp ? LEARN_BOTH : 8'h00);
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				qmax_reg[c] <= QMAX_RST;
				cyc_reg[c] <= 16'h0000;
				dod_reg[c] <= 16'h0000;
				upd_reg[c] <= 8'h00;
			end else if (sel) begin
				// a hardware update wins over a host write in the same cycle
				if (qmax_upd) begin
					qmax_reg[c] <= qmax_value;
					cyc_reg[c] <= cyc_reg[c] + 16'h0001;
				end else if (wr_qmax) begin
					qmax_reg[c] <= merge16(qmax_reg[c]);
				end
				if (dod_upd) dod_reg[c] <= dod_value;
				if (gauge_rise) begin
					upd_reg[c] <= LEARN_QMAX;
				end else begin
					upd_reg[c] <= upd_reg[c] | learn_bits;
				end
			end
		end
	end

	// pulse-load voltage difference, slewed by at most the step per update
	wire [15:0] up_lim = pulse_reg + step_reg;
	wire [15:0] dn_lim = (pulse_reg > step_reg) ? pulse_reg - step_reg : 16'h0000;
	wire [15:0] pulse_next = (grid_delta > up_lim) ? up_lim :
		(grid_delta < dn_lim) ? dn_lim : grid_delta;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pulse_reg <= PULSE_RST;
		end else if (grid_upd) begin
			pulse_reg <= pulse_next;
		end else if (wr_pulse) begin
			pulse_reg <= merge16(pulse_reg);
		end
	end

	// one-second tick shared by both timers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg <= 32'h00000000;
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= (tick_cnt_reg == 32'(TICKS - 1));
			tick_cnt_reg <= (tick_cnt_reg == 32'(TICKS - 1)) ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
		end
	end

	// current classification against thresholds
	wire signed [16:0] avg_x = {meas_avg[15], meas_avg};
	wire signed [16:0] quit_x = {1'b0, quit_reg};
	wire dsg_now = avg_x < -$signed({1'b0, dsg_thr_reg});
	wire chg_now = avg_x > $signed({1'b0, chg_thr_reg});
	wire below = avg_x <= -quit_x;
	wire above = avg_x >= quit_x;
	wire in_band = !below && !above;
	wire relaxing = (state_reg == ST_RELAX) || (state_reg == ST_EXIT);

	// timer hookup: phase timer for relax entry and exit, second for ocv wait
	assign ph_if.tick = tick_reg;
	assign rx_if.tick = tick_reg;
	assign ph_if.run = (state_reg == ST_DSG_WAIT) || (state_reg == ST_CHG_WAIT) || (state_reg == ST_EXIT);
	assign ph_if.limit = (state_reg == ST_DSG_WAIT) ? dsg_relax_reg :
		(state_reg == ST_CHG_WAIT) ? chg_relax_reg : quit_relax_reg;
	assign rx_if.run = relaxing;
	assign rx_if.limit = OCV_WAIT_S;
	rlx_timer u_phase (.clk_sys(clk_sys), .rst_n(rst_n), .tif(ph_if));
	rlx_timer u_relax (.clk_sys(clk_sys), .rst_n(rst_n), .tif(rx_if));

	// relaxation tracking
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_FLOW: begin
				if (meas_valid && in_band && prev_below_reg) state_next = ST_DSG_WAIT;
				else if (meas_valid && in_band && prev_above_reg) state_next = ST_CHG_WAIT;
			end
			ST_DSG_WAIT, ST_CHG_WAIT: begin
				if (meas_valid && !in_band) state_next = ST_FLOW;
				else if (ph_if.expired) state_next = ST_RELAX;
			end
			ST_RELAX: begin
				if (meas_valid && (dsg_now || chg_now)) state_next = ST_EXIT;
			end
			ST_EXIT: begin
				if (meas_valid && !(dsg_now || chg_now)) state_next = ST_RELAX;
				else if (ph_if.expired) state_next = ST_FLOW;
			end
			default: state_next = ST_FLOW;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_FLOW;
			prev_below_reg <= 1'b0;
			prev_above_reg <= 1'b0;
			relax_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			relax_reg <= (state_next == ST_RELAX) || (state_next == ST_EXIT);
			if (meas_valid) begin
				prev_below_reg <= below;
				prev_above_reg <= above;
			end
		end
	end

	// flags and one ocv sample per relaxation
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dsg_mode_reg <= 1'b1;
			dsg_flow_reg <= 1'b0;
			chg_flow_reg <= 1'b0;
			ocv_take_reg <= 1'b0;
			ocv_done_reg <= 1'b0;
			ocv_volt_reg <= 16'h0000;
		end else begin
			if (meas_valid) begin
				dsg_mode_reg <= !(meas_avg > 16'sh0000);
				dsg_flow_reg <= dsg_now;
				chg_flow_reg <= chg_now;
			end
			ocv_take_reg <= 1'b0;
			if (!relaxing) begin
				ocv_done_reg <= 1'b0;
			end else if (rx_if.expired && meas_valid && meas_dvdt < DVDT_MAX_UV && !ocv_done_reg) begin
				ocv_take_reg <= 1'b1;
				ocv_done_reg <= 1'b1;
				ocv_volt_reg <= meas_volt;
			end
		end
	end

	// discharge-cycle sums; the divide is wide but runs once per cycle end
	wire signed [31:0] pwr = meas_cur * $signed({1'b0, meas_volt});
	wire cycle_end = dsg_flow_reg && meas_valid && !dsg_now && n_reg != 24'h000000;
	wire signed [39:0] i_avg = isum_reg / $signed({16'h0000, n_reg});
	wire signed [55:0] p_avg = psum_reg / $signed({32'h00000000, n_reg});
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			isum_reg <= 40'sh0;
			psum_reg <= 56'sh0;
			n_reg <= 24'h000000;
			avg_i_reg <= 16'sh0000;
			avg_p_reg <= 32'sh00000000;
		end else if (cycle_end) begin
			avg_i_reg <= i_avg[15:0];
			avg_p_reg <= p_avg[31:0];
			isum_reg <= 40'sh0;
			psum_reg <= 56'sh0;
			n_reg <= 24'h000000;
		end else if (meas_valid && dsg_now) begin
			isum_reg <= isum_reg + 40'(meas_cur);
			psum_reg <= psum_reg + 56'(pwr);
			n_reg <= n_reg + 24'h000001;
		end
	end

	// checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_dsg_enter;
		state_reg == ST_FLOW && meas_valid && in_band && prev_below_reg;
	endsequence
	sequence s_chg_enter;
		state_reg == ST_FLOW && meas_valid && in_band && !prev_below_reg && prev_above_reg;
	endsequence
	sequence s_exit_done;
		state_reg == ST_EXIT ##1 state_reg == ST_FLOW;
	endsequence
	AST_DSG_MODE: assert property (meas_valid |=> dsg_mode == ($past(meas_avg) <= 16'sh0000))
		else $error("discharge mode flag wrong");
	AST_DSG_FLOW: assert property (meas_valid && meas_avg > 16'sh0000 |=> !dsg_flow)
		else $error("discharge flow flagged while charging");
	AST_CHG_FLOW: assert property (meas_valid && !chg_now |=> !chg_flow)
		else $error("charge flow flagged below threshold");
	AST_DSG_WAIT: assert property (s_dsg_enter |=> state_reg == ST_DSG_WAIT && ph_if.run)
		else $error("discharge relax timer not started");
	AST_CHG_WAIT: assert property (s_chg_enter |=> state_reg == ST_CHG_WAIT)
		else $error("charge relax timer not started");
	AST_OCV: assert property (ocv_take |-> $past(rx_if.expired && relax_active))
		else $error("ocv taken before relax wait");
	AST_EXIT: assert property (s_exit_done |-> $past(ph_if.expired, 1))
		else $error("relaxation left before quit delay");
	AST_GAUGE: assert property (gauge_rise |=> gauging_enabled_flag && upd_reg[cell_sel] == LEARN_QMAX)
		else $error("gauging enable did not set learning status");
	AST_CYCLE: assert property (qmax_upd |=> cyc_reg[cell_sel] == $past(cyc_reg[cell_sel]) + 16'h0001)
		else $error("cycle count not advanced");
	AST_STEP: assert property (grid_upd && !wr_pulse |=> pulse_reg <= $past(up_lim) && pulse_reg >= $past(dn_lim))
		else $error("pulse difference step exceeded");
	AST_ABANDON: assert property (state_reg == ST_DSG_WAIT && meas_valid && !in_band |=> state_reg == ST_FLOW)
		else $error("relax timer not abandoned");
endmodule

// ---- tb/rlx_meas_src.sv ----
`timescale 1ns/1ps
// measurement source: one sample every second cycle at the level the bench asks for
module rlx_meas_src (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// requested levels
	input wire logic signed [15:0] avg_set,
	input wire logic signed [15:0] dvdt_set,
	// sample lines
	output logic meas_valid,
	output logic signed [15:0] meas_cur,
	output logic signed [15:0] meas_avg,
	output logic [15:0] meas_volt,
	output logic signed [15:0] meas_dvdt
);
	// sample strobe toggles, so a sample comes every second cycle, at half rate
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			meas_valid <= 1'b0;
		end else begin
			meas_valid <= !meas_valid;
		end
	end
	// between samples the lines carry inverted data, so a stale capture shows up
	assign meas_avg = meas_valid ? avg_set : ~avg_set;
	assign meas_cur = meas_valid ? avg_set : ~avg_set;
	assign meas_volt = meas_valid ? 16'h0E74 : 16'hF18B;
	assign meas_dvdt = meas_valid ? dvdt_set : ~dvdt_set;
endmodule

// ---- tb/test_rlx_tracker.sv ----
`timescale 1ns/1ps
module test_rlx_tracker import rlx_pkg::*;;
	logic clk_sys, arst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready;
	logic bvalid, arready, rvalid, meas_valid, learn_imp, qmax_upd, learn_qmax, dod_upd, grid_upd;
	logic dsg_mode, dsg_flow, chg_flow, relax_active, ocv_take, gauging_enabled_flag;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic signed [15:0] avg_set, dvdt_set, m_cur, m_avg, m_dvdt;
	logic [15:0] m_volt, ocv_voltage, grid_delta;
	int bad_count, check_count, i, n;
	// reset-value table: offset and expected word
	logic [7:0] offs [13] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h28,
		8'h3C, 8'h04, 8'h00, 8'h2C, 8'h30};
	logic [31:0] exps [13] = '{32'h3C, 32'h4B, 32'h28, 32'h708, 32'h3C, 32'h1, 32'hA,
		32'h3E8, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0};
	rlx_tracker #(.TICKS(4)) rlx_tracker_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.meas_valid(meas_valid), .meas_cur(m_cur), .meas_avg(m_avg), .meas_volt(m_volt),
		.meas_dvdt(m_dvdt), .grid_upd(grid_upd), .grid_delta(grid_delta), .qmax_upd(qmax_upd),
		.qmax_value(16'h04D2), .learn_qmax(learn_qmax), .learn_imp(learn_imp), .dod_upd(dod_upd),
		.dod_value(16'h0055), .dsg_mode(dsg_mode), .dsg_flow(dsg_flow), .chg_flow(chg_flow),
		.relax_active(relax_active), .ocv_take(ocv_take), .ocv_voltage(ocv_voltage),
		.gauging_enabled_flag(gauging_enabled_flag));
	rlx_meas_src rlx_meas_src_inst (.clk_sys(clk_sys), .arst_n(arst_n), .avg_set(avg_set),
		.dvdt_set(dvdt_set), .meas_valid(meas_valid), .meas_cur(m_cur), .meas_avg(m_avg),
		.meas_volt(m_volt), .meas_dvdt(m_dvdt));
	// free-running 50 MHz clock
	always #10 clk_sys = ~clk_sys;
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// write: address and data offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
		int k;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (!(bready && bvalid === 1'b1) && k < 200);
		rsp = bresp;
		bready <= 1'b0;
	endtask
	// read: response taken at the edge where rvalid is seen with rready up
	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
		int k;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && k < 200);
		v = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] exp);
		rd(a, d, r);
		chk(d, exp);
	endtask
	// new averaged level, then let a few samples land
	task setc(input logic signed [15:0] v);
		@(posedge clk_sys);
		avg_set <= v;
		repeat (6) @(posedge clk_sys);
	endtask
	// bounded wait for the relaxation flag to reach a level
	task wait_relax(input logic lvl);
		n = 0;
		while (relax_active !== lvl && n < 200) begin
			@(posedge clk_sys);
			n++;
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// watchdog, well beyond the half-hour settle at four cycles a second
	initial begin
		#1000000;
		bad_count++;
		stop_test;
	end
	// main sequence
	initial begin
		{clk_sys, arst_n, awvalid, wvalid, bready, arvalid, rready, learn_imp, qmax_upd} = '0;
		{learn_qmax, dod_upd, grid_upd} = '0;
		{awaddr, araddr, wdata} = '0;
		grid_delta = 16'h0064;
		avg_set = 16'sh0000;
		dvdt_set = 16'sh000A;
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		for (i = 0; i < 13; i++) rc(offs[i], exps[i]);
		rd(8'h44, d, r);
		chk(r, RESP_SLVERR);
		wr(8'h44, 32'h1, r);
		chk(r, RESP_SLVERR);
		wr(OFF_PROF, 32'hFF, r);
		rc(OFF_PROF, 32'h3);
		$display("test registers finished");
		wr(OFF_CTRL, 32'h1, r);
		chk(gauging_enabled_flag, 1'b1);
		rd(OFF_STATUS, d, r);
		chk(d[15:8], 8'h01);
		@(posedge clk_sys) learn_imp <= 1'b1;
		@(posedge clk_sys) learn_imp <= 1'b0;
		rd(OFF_STATUS, d, r);
		chk(d[15:8], 8'h03);
		@(posedge clk_sys) qmax_upd <= 1'b1;
		@(posedge clk_sys) qmax_upd <= 1'b0;
		rc(OFF_QMAX, 32'h4D2);
		rc(OFF_CYCLE, 32'h1);
		// back to cell 0: its records must not have seen the cell 1 updates
		wr(OFF_PROF, 32'h0, r);
		@(posedge clk_sys) {learn_qmax, dod_upd, grid_upd} <= 3'b111;
		@(posedge clk_sys) {learn_qmax, dod_upd, grid_upd} <= 3'b000;
		rd(OFF_STATUS, d, r);
		chk(d[15:8], LEARN_QMAX);
		rc(OFF_CYCLE, 32'h0);
		rc(OFF_DOD, 32'h55);
		// target far above the default, so the step limit must clamp it
		rc(OFF_PULSE, 32'(PULSE_RST + STEP_RST));
		$display("test learning finished");
		// short relax times keep the run brief; quit level stays below both detect levels
		wr(OFF_DSG_RELAX, 32'h3, r);
		wr(OFF_CHG_RELAX, 32'h2, r);
		setc(16'sh0064);
		chk({dsg_mode, chg_flow}, 2'b01);
		setc(-16'sh0064);
		chk({dsg_mode, dsg_flow}, 2'b11);
		setc(16'sh0000);
		setc(-16'sh0064);
		repeat (20) @(posedge clk_sys);
		chk(relax_active, 1'b0);
		setc(16'sh0000);
		chk(relax_active, 1'b0);
		wait_relax(1'b1);
		chk(relax_active, 1'b1);
		dvdt_set <= 16'sh0002;
		n = 0;
		while (ocv_take !== 1'b1 && n < 9000) begin
			@(posedge clk_sys);
			n++;
		end
		chk(n >= 7190 && n < 9000, 1'b1);
		chk(ocv_voltage, 16'h0E74);
		setc(-16'sh0064);
		wait_relax(1'b0);
		chk(relax_active, 1'b0);
		$display("test discharge relax finished");
		setc(16'sh0064);
		setc(16'sh0000);
		wait_relax(1'b1);
		chk(relax_active, 1'b1);
		// every discharge cycle ran at -100 mA and 0x0E74 mV
		rc(OFF_AVG_I, 32'hFFFFFF9C);
		rc(OFF_AVG_P, 32'hFFFA5AB0);
		$display("test charge relax finished");
		stop_test;
	end
endmodule
